// >>> verilog/osr_defs.svh
// Query selects, bit positions and reset values of the operation status bank.
`ifndef OSR_DEFS_SVH
`define OSR_DEFS_SVH

`define OSR_NUM_REGS      5
`define OSR_NUM_SENSORS   4
`define OSR_REG_W         16

// Register groups; a query select is {group, is_event}.
`define OSR_GRP_OP        3'h0
`define OSR_GRP_CAL       3'h1
`define OSR_GRP_MEAS      3'h2
`define OSR_GRP_TRG       3'h3
`define OSR_GRP_INIT      3'h4

`define OSR_SEL_OP_COND   4'h0
`define OSR_SEL_OP_EV     4'h1
`define OSR_SEL_CAL_COND  4'h2
`define OSR_SEL_CAL_EV    4'h3
`define OSR_SEL_MEAS_COND 4'h4
`define OSR_SEL_MEAS_EV   4'h5
`define OSR_SEL_TRG_COND  4'h6
`define OSR_SEL_TRG_EV    4'h7
`define OSR_SEL_INIT_COND 4'h8
`define OSR_SEL_INIT_EV   4'h9

// Top-level bit positions.
`define OSR_OP_CAL_BIT    0
`define OSR_OP_MEAS_BIT   4
`define OSR_OP_TRG_BIT    5
`define OSR_OP_INIT_BIT   10
`define OSR_OP_LLIM_BIT   11
`define OSR_OP_ULIM_BIT   12

// Sensor A..D occupy bits 1..4 of each sub-register.
`define OSR_SUB_LSB       1
`define OSR_SUB_MSB       4

// Bits that may ever be nonzero.
`define OSR_OP_MASK       16'h1C31
`define OSR_SUB_MASK      16'h001E

`define OSR_EV_RESET      16'h0000
`define OSR_INIT_PEND_RST 4'hF

`endif

// >>> verilog/osr_pkg.sv
// Types of the operation status bank.
package osr_pkg;
  typedef logic [3:0]  osr_sel_t;
  typedef logic [15:0] osr_word_t;
  // Activity state reported by each sensor, Gray coded along idle, wait, measure.
  typedef enum logic [1:0] {
    OSR_ST_IDLE    = 2'b00,
    OSR_ST_TRGWAIT = 2'b01,
    OSR_ST_MEAS    = 2'b11,
    OSR_ST_OTHER   = 2'b10
  } osr_sstate_t;
endpackage

// >>> verilog/osr_status_bank.sv
// Operation status bank: condition and latched event registers for four sensors.
`timescale 1ns/10ps
`include "osr_defs.svh"

// Summary of operation
// - Operation condition register shows operations in progress now, tracking sensor activity.
// - Operation event register latches occurrences since last read; reading clears it.
// - Top bit 0 is set while any sensor calibrates.
// - Top bit 4 is set while any sensor measures.
// - Top bit 5 is set while any sensor waits for trigger.
// - Top bit 10 is set while any sensor initialises.
// - Top bit 11 is set while a displayed value is below lower limit.
// - Top bit 12 is set while a displayed value is above upper limit.
// - Bit 15 and all unused top-level bits always read zero.
// - Calibration bits 1-4 follow sensors A-D calibrating; other bits read zero.
// - Calibration events catch start, end or both per transition filter.
// - Measurement bits 1-4 follow sensors A-D measuring.
// - Measurement events catch start, end or both per transition filter.
// - Trigger bits 1-4 show trigger wait; a trigger clears that bit.
// - Trigger events catch entering, leaving or both per transition filter.
// - Initialisation bits 1-4 follow sensors A-D initialising.
// - Initialisation starts at power-up, on attach, or on reset/preset command.
// - Initialisation events catch start, end or both per transition filter.
module osr_status_bank (
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic [3:0]          sens_cal,
  input  wire logic [7:0]          sens_state,
  input  wire logic [3:0]          sens_init,
  input  wire logic [3:0]          sens_attach,
  input  wire logic [3:0]          trg_in,
  input  wire logic                llim_fail,
  input  wire logic                ulim_fail,
  input  wire logic                preset_cmd,
  input  wire logic [4:0][15:0]    ptr_filt,
  input  wire logic [4:0][15:0]    ntr_filt,
  input  wire logic                qry_valid,
  input  wire osr_pkg::osr_sel_t   qry_sel,
  output logic                     rsp_valid,
  output osr_pkg::osr_word_t       rsp_data
);
  import osr_pkg::*;

  localparam int SYNC_W = 26;

  logic [SYNC_W-1:0]  sync1_q;
  logic [SYNC_W-1:0]  sync2_q;
  logic [3:0]         trg_prev_q;
  logic [3:0]         attach_prev_q;
  logic [3:0]         trg_seen_q;
  logic [3:0]         trg_seen_d;
  logic [3:0]         init_pend_q;
  logic [3:0]         init_pend_d;
  logic [4:0][15:0]   cond_prev_q;
  logic [4:0][15:0]   ev_q;
  logic               rsp_valid_q;
  osr_word_t          rsp_data_q;

  wire [SYNC_W-1:0] pin_w = {ulim_fail, llim_fail, trg_in, sens_attach, sens_init, sens_state, sens_cal};

  // Pins come from the sensors' own domains; two flops before any use.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_w;
      sync2_q <= sync1_q;
    end
  end

  wire [3:0] cal_s    = sync2_q[3:0];
  wire [7:0] state_s  = sync2_q[11:4];
  wire [3:0] init_s   = sync2_q[15:12];
  wire [3:0] attach_s = sync2_q[19:16];
  wire [3:0] trg_s    = sync2_q[23:20];
  wire       llim_s   = sync2_q[24];
  wire       ulim_s   = sync2_q[25];

  wire [3:0] trg_rise    = trg_s & ~trg_prev_q;
  wire [3:0] attach_rise = attach_s & ~attach_prev_q;

  logic [3:0] wait_w;
  logic [3:0] meas_w;
  genvar gs;
  generate
    for (gs = 0; gs < `OSR_NUM_SENSORS; gs++) begin : g_sens
      assign wait_w[gs] = (osr_sstate_t'(state_s[2*gs+1 -: 2]) == OSR_ST_TRGWAIT);
      assign meas_w[gs] = (osr_sstate_t'(state_s[2*gs+1 -: 2]) == OSR_ST_MEAS);
    end
  endgenerate

  // A trigger masks the wait bit until the sensor's own state leaves wait.
  assign trg_seen_d = wait_w & (trg_seen_q | trg_rise);
  wire [3:0] trg_cond = wait_w & ~trg_seen_d;

  // Pending initialisation from power-up, attach or preset, until the sensor takes over or is detached.
  assign init_pend_d = (init_pend_q | attach_rise | {4{preset_cmd}}) & attach_s & ~init_s;
  wire [3:0] init_cond = init_pend_q | init_s;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      trg_prev_q    <= '0;
      attach_prev_q <= '0;
      trg_seen_q    <= '0;
      init_pend_q   <= `OSR_INIT_PEND_RST;
    end else begin
      trg_prev_q    <= trg_s;
      attach_prev_q <= attach_s;
      trg_seen_q    <= trg_seen_d;
      init_pend_q   <= init_pend_d;
    end
  end

  logic [4:0][15:0] cond_w;
  assign cond_w[`OSR_GRP_CAL]  = {11'h000, cal_s, 1'b0};
  assign cond_w[`OSR_GRP_MEAS] = {11'h000, meas_w, 1'b0};
  assign cond_w[`OSR_GRP_TRG]  = {11'h000, trg_cond, 1'b0};
  assign cond_w[`OSR_GRP_INIT] = {11'h000, init_cond, 1'b0};

  wire sum_cal  = |cond_w[`OSR_GRP_CAL][`OSR_SUB_MSB:`OSR_SUB_LSB];
  wire sum_meas = |cond_w[`OSR_GRP_MEAS][`OSR_SUB_MSB:`OSR_SUB_LSB];
  wire sum_trg  = |cond_w[`OSR_GRP_TRG][`OSR_SUB_MSB:`OSR_SUB_LSB];
  wire sum_init = |cond_w[`OSR_GRP_INIT][`OSR_SUB_MSB:`OSR_SUB_LSB];

  // Unused top-level bits and bit 15 stay zero.
  assign cond_w[`OSR_GRP_OP] = {3'h0, ulim_s, llim_s, sum_init, 4'h0,
                                sum_trg, sum_meas, 3'h0, sum_cal};

  wire [2:0] qry_grp = qry_sel[3:1];
  wire       qry_ev  = qry_sel[0];
  wire       qry_ok  = (qry_grp <= `OSR_GRP_INIT);

  genvar gr;
  generate
    for (gr = 0; gr < `OSR_NUM_REGS; gr++) begin : g_reg
      wire [15:0] rise_w = cond_w[gr] & ~cond_prev_q[gr];
      wire [15:0] fall_w = ~cond_w[gr] & cond_prev_q[gr];
      wire        clr_w  = qry_valid & qry_ev & (qry_grp == 3'(gr));
      // A new edge in the clearing cycle is kept: set wins over read-clear.
      wire [15:0] ev_d   = (ev_q[gr] & ~{16{clr_w}})
                         | (rise_w & ptr_filt[gr]) | (fall_w & ntr_filt[gr]);
      always_ff @(posedge clk_sys) begin
        if (!rstn) begin
          cond_prev_q[gr] <= '0;
          ev_q[gr]        <= `OSR_EV_RESET;
        end else begin
          cond_prev_q[gr] <= cond_w[gr];
          ev_q[gr]        <= ev_d;
        end
      end
    end
  endgenerate

  wire [15:0] sel_cond = qry_ok ? cond_w[qry_grp] : 16'h0000;
  wire [15:0] sel_ev   = qry_ok ? ev_q[qry_grp] : 16'h0000;
  wire [15:0] rd_w     = qry_ev ? sel_ev : sel_cond;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 16'h0000;
    end else begin
      rsp_valid_q <= qry_valid;
      rsp_data_q  <= qry_valid ? rd_w : rsp_data_q;
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_data  = rsp_data_q;

  AST_SUM_CAL: assert property (@(posedge clk_sys) disable iff (!rstn)
    cond_w[`OSR_GRP_OP][`OSR_OP_CAL_BIT] == (|sync2_q[3:0]))
    else $error("calibration summary bit wrong");
  AST_SUM_MEAS: assert property (@(posedge clk_sys) disable iff (!rstn)
    cond_w[`OSR_GRP_OP][`OSR_OP_MEAS_BIT] == (|meas_w))
    else $error("measurement summary bit wrong");
  AST_TRG_CLEAR: assert property (@(posedge clk_sys) disable iff (!rstn)
    (trg_rise[0] && wait_w[0]) |-> !cond_w[`OSR_GRP_TRG][1])
    else $error("trigger did not clear the wait bit");
  AST_SUM_INIT: assert property (@(posedge clk_sys) disable iff (!rstn)
    cond_w[`OSR_GRP_OP][`OSR_OP_INIT_BIT] == (|(init_pend_q | init_s)))
    else $error("initialisation summary bit wrong");
  AST_LIMITS: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(sync1_q[24]) |=> cond_w[`OSR_GRP_OP][`OSR_OP_LLIM_BIT])
    else $error("lower limit bit late");
  AST_ULIM: assert property (@(posedge clk_sys) disable iff (!rstn)
    cond_w[`OSR_GRP_OP][`OSR_OP_ULIM_BIT] == $past(sync1_q[25]))
    else $error("upper limit bit wrong");
  AST_RESERVED: assert property (@(posedge clk_sys) disable iff (!rstn)
    ((cond_w[0] & ~`OSR_OP_MASK) == 16'h0000) && ((ev_q[1] & ~`OSR_SUB_MASK) == 16'h0000))
    else $error("unused bit set");
  AST_EV_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ev_q[1][1] && !(qry_valid && qry_sel == `OSR_SEL_CAL_EV)) |=> ev_q[1][1])
    else $error("event bit lost before read");
  AST_READ_CLR: assert property (@(posedge clk_sys) disable iff (!rstn)
    (qry_valid && qry_sel == `OSR_SEL_OP_EV && cond_w[0] == cond_prev_q[0]) |=> ev_q[0] == 16'h0000)
    else $error("event register not cleared by read");
  AST_READ_DATA: assert property (@(posedge clk_sys) disable iff (!rstn)
    (qry_valid && qry_sel == `OSR_SEL_OP_COND) |=> (rsp_valid && rsp_data == $past(cond_w[0])))
    else $error("condition read wrong");
  AST_CAL_EDGE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cond_w[1][2] && !cond_prev_q[1][2] && ptr_filt[1][2]) |=> ev_q[1][2])
    else $error("calibration start not latched");
  AST_INIT_PWR: assert property (@(posedge clk_sys)
    !rstn |=> init_pend_q == `OSR_INIT_PEND_RST)
    else $error("power-up initialisation not pending");
  AST_SUM_TRG: assert property (@(posedge clk_sys) disable iff (!rstn)
    cond_w[`OSR_GRP_OP][`OSR_OP_TRG_BIT] == (|trg_cond))
    else $error("trigger summary bit wrong");
  AST_SUM_OR: assert property (@(posedge clk_sys) disable iff (!rstn)
    cond_w[`OSR_GRP_OP][`OSR_OP_MEAS_BIT] == (|cond_w[`OSR_GRP_MEAS][4:1]))
    else $error("summary bit does not follow its sub-register");
  AST_CAL_MAP: assert property (@(posedge clk_sys) disable iff (!rstn)
    cond_w[`OSR_GRP_CAL] == {11'h000, sync2_q[3:0], 1'b0})
    else $error("calibration condition bits misplaced");
  AST_MEAS_MAP: assert property (@(posedge clk_sys) disable iff (!rstn)
    cond_w[`OSR_GRP_MEAS][4:1] == meas_w)
    else $error("measurement condition bits misplaced");
  AST_INIT_MAP: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cond_w[`OSR_GRP_INIT][4:1] & init_s) == init_s)
    else $error("initialising sensor not shown");
  AST_MEAS_FALL: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!cond_w[2][1] && cond_prev_q[2][1] && ntr_filt[2][1]) |=> ev_q[2][1])
    else $error("measurement end not latched");
  AST_TRG_RISE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cond_w[3][1] && !cond_prev_q[3][1] && ptr_filt[3][1]) |=> ev_q[3][1])
    else $error("trigger wait entry not latched");
  AST_INIT_RISE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cond_w[4][3] && !cond_prev_q[4][3] && ptr_filt[4][3]) |=> ev_q[4][3])
    else $error("initialisation start not latched");
  AST_RSP_PULSE: assert property (@(posedge clk_sys) disable iff (!rstn)
    qry_valid |=> rsp_valid)
    else $error("query not answered");
  AST_PRESET: assert property (@(posedge clk_sys) disable iff (!rstn)
    (preset_cmd && attach_s[2] && !init_s[2]) |=> init_pend_q[2])
    else $error("preset did not start initialisation");

  COV_TRG_SEEN: cover property (@(posedge clk_sys) disable iff (!rstn) trg_rise[0] && wait_w[0]);
  COV_EV_READ:  cover property (@(posedge clk_sys) disable iff (!rstn)
    qry_valid && qry_ev && (sel_ev != 16'h0000));
  COV_ATTACH:   cover property (@(posedge clk_sys) disable iff (!rstn) attach_rise[2]);
  COV_PRESET:   cover property (@(posedge clk_sys) disable iff (!rstn) preset_cmd && attach_s[2]);
  COV_SET_CLR:  cover property (@(posedge clk_sys) disable iff (!rstn)
    qry_valid && qry_sel == `OSR_SEL_MEAS_EV && (|(meas_w ^ cond_prev_q[2][4:1])));

endmodule

// >>> tb/osr_sensor_model.sv
// Behavioural model of the four sensors and the limit monitor.
`timescale 1ns/10ps
module osr_sensor_model
  import osr_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic [3:0] cal_cmd,
  input  wire logic [7:0] state_cmd,
  input  wire logic [3:0] init_cmd,
  input  wire logic [3:0] attach_cmd,
  input  wire logic [3:0] fire_cmd,
  input  wire logic [1:0] lim_cmd,
  output logic      [3:0] sens_cal,
  output logic      [7:0] sens_state,
  output logic      [3:0] sens_init,
  output logic      [3:0] sens_attach,
  output logic      [3:0] trg_in,
  output logic            llim_fail,
  output logic            ulim_fail
);
  logic [3:0][3:0] hist = '0;
  logic [3:0]      done = '0;
  // A trigger sampled four cycles earlier moves a waiting sensor on to measuring.
  always @(negedge clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      hist[i] <= {hist[i][2:0], fire_cmd[i]};
      done[i] <= (state_cmd[2*i+:2] == OSR_ST_TRGWAIT) && (done[i] || hist[i][3]);
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      sens_state[2*i+:2] = done[i] ? OSR_ST_MEAS : state_cmd[2*i+:2];
    end
  end
  assign sens_cal    = cal_cmd;
  assign sens_init   = init_cmd;
  assign sens_attach = attach_cmd;
  assign trg_in      = fire_cmd;
  assign llim_fail   = lim_cmd[0];
  assign ulim_fail   = lim_cmd[1];
endmodule

// >>> tb/test_osr_status_bank.sv
// Self-checking testbench of the operation status bank.
`timescale 1ns/10ps
module test_osr_status_bank;
  import osr_pkg::*;
  logic             clk_sys = 1'b0, rstn = 1'b0, preset_cmd = 1'b0, qry_valid = 1'b0;
  logic             llim_fail, ulim_fail, rsp_valid;
  logic [3:0]       cal_cmd = '0, init_cmd = '0, attach_cmd = '0, fire_cmd = '0;
  logic [3:0]       sens_cal, sens_init, sens_attach, trg_in;
  logic [7:0]       state_cmd = '0, sens_state;
  logic [1:0]       lim_cmd = '0;
  logic [4:0][15:0] ptr_filt = '0, ntr_filt = '0;
  osr_sel_t         qry_sel = '0;
  osr_word_t        rsp_data;
  osr_word_t        tab_b[10] = '{16'h0831, 16'h0831, 16'h000A, 16'h000A, 16'h0004, 16'h0004, 16'h0002, 16'h0002, 16'h0000, 16'h0000};
  osr_word_t        tab_c[10] = '{16'h0810, 16'h0021, 16'h0000, 16'h000A, 16'h0006, 16'h0000, 16'h0000, 16'h0002, 16'h0000, 16'h0000};
  osr_word_t        tab_d[10] = '{16'h1C10, 16'h1400, 16'h0000, 16'h0000, 16'h0006, 16'h0000, 16'h0000, 16'h0000, 16'h0008, 16'h0008};
  int               bad_count = 0, n_checks = 0;

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  osr_sensor_model u_osr_sensor_model (.clk_sys, .cal_cmd, .state_cmd, .init_cmd, .attach_cmd, .fire_cmd, .lim_cmd,
    .sens_cal, .sens_state, .sens_init, .sens_attach, .trg_in, .llim_fail, .ulim_fail);
  osr_status_bank u_osr_status_bank (.clk_sys, .rstn, .sens_cal, .sens_state, .sens_init, .sens_attach, .trg_in,
    .llim_fail, .ulim_fail, .preset_cmd, .ptr_filt, .ntr_filt, .qry_valid, .qry_sel, .rsp_valid, .rsp_data);

  task automatic chk(osr_word_t seen, osr_word_t exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t: read %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(int sel, osr_word_t exp);
    @(negedge clk_sys);
    qry_valid = 1'b1;
    qry_sel = osr_sel_t'(sel);
    @(negedge clk_sys);
    qry_valid = 1'b0;
    chk({15'h0000, rsp_valid}, 16'h0001);
    chk(rsp_data, exp);
  endtask

  task automatic rd_all(osr_word_t t[10]);
    for (int s = 0; s < 10; s++) begin
      rd(s, t[s]);
    end
  endtask

  task automatic idle(int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic tally_and_finish;
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    idle(3);
    ptr_filt = {5{16'hFFFF}};
    for (int s = 0; s < 16; s++) begin
      rd(s, 16'h0000);
    end
    cal_cmd = 4'h5;
    state_cmd = 8'h8D;
    lim_cmd = 2'h1;
    idle(6);
    rd_all(tab_b);
    for (int s = 1; s < 10; s += 2) begin
      rd(s, 16'h0000);
    end
    // Only falling edges are latched while the trigger fires and calibration ends.
    ptr_filt = '0;
    ntr_filt = {5{16'hFFFF}};
    cal_cmd = '0;
    fire_cmd = 4'h1;
    idle(12);
    rd_all(tab_c);
    ptr_filt = {5{16'hFFFF}};
    ntr_filt = '0;
    attach_cmd = 4'h4;
    lim_cmd = 2'h3;
    idle(6);
    rd(8, 16'h0008);
    init_cmd = 4'h4;
    idle(6);
    init_cmd = '0;
    idle(6);
    rd(8, 16'h0000);
    preset_cmd = 1'b1;
    idle(1);
    preset_cmd = 1'b0;
    idle(6);
    rd_all(tab_d);
    tally_and_finish();
  end

  initial begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    tally_and_finish();
  end
endmodule
